//--- rtl/audio_serial_pin_control.sv
`timescale 1ns/1ps
`include "audio_serial_regs.svh"
module audio_serial_pin_control #(
	parameter int W = `AS_WORD_W,
	parameter int TX_N = `AS_TX_COUNT,
	parameter int BCLK_HALF = `AS_BCLK_HALF,
	parameter int FIFO_DEPTH = `AS_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic rxLinkClk,
	input wire logic rxMaster,
	input wire logic txMaster,
	input wire logic rxEnable0,
	input wire logic [TX_N-1:0] txEnable,
	input wire logic softReset,
	input wire logic stopMode,
	input wire logic txValid,
	input wire logic [TX_N*W-1:0] txData,
	output logic txReady,
	output logic txUnderrun,
	output logic [W-1:0] rxWord,
	output logic rxWordRight,
	output logic rxWordValid,
	output logic rxBitClkOut,
	output logic rxBitClkOe,
	input wire logic rxWordSelIn,
	output logic rxWordSelOut,
	output logic rxWordSelOe,
	input wire logic rxSerialIn0,
	input wire logic txBitClkIn,
	output logic txBitClkOut,
	output logic txBitClkOe,
	input wire logic txWordSelIn,
	output logic txWordSelOut,
	output logic txWordSelOe,
	output logic [TX_N-1:0] txSerialOut
);
	localparam int CW = $clog2(W);
	localparam int DW = $clog2(BCLK_HALF + 1);

	initial begin
		if (W < 2 || TX_N < 1 || BCLK_HALF < 1)
			$error("audio_serial_pin_control: unsupported parameters");
	end

	// ---------------- clk domain: control levels
	logic rxActive, txActive;
	logic [TX_N-1:0] txOn;
	logic genRun;

	always_comb begin
		rxActive = rxEnable0 && !softReset && !stopMode;
		txActive = (|txEnable) && !softReset && !stopMode;
		txOn = txEnable & {TX_N{!softReset && !stopMode}};
		genRun = (rxMaster && rxActive) || (txMaster && txActive);
	end

	// ---------------- master bit clock and word select generator
	logic [DW-1:0] divCnt_r, divCnt_nxt;
	logic [CW-1:0] bitCnt_r, bitCnt_nxt;
	logic mClk_r, mClk_nxt, mWs_r, mWs_nxt;
	logic mFall, mBound;

	always_comb begin
		divCnt_nxt = divCnt_r;
		bitCnt_nxt = bitCnt_r;
		mClk_nxt = mClk_r;
		mWs_nxt = mWs_r;
		mFall = 1'b0;
		mBound = 1'b0;
		if (!genRun) begin
			divCnt_nxt = '0;
			bitCnt_nxt = CW'(W - 1);
			mClk_nxt = `AS_IDLE_CLK;
			mWs_nxt = `AS_IDLE_WS;
		end else if (divCnt_r == DW'(BCLK_HALF - 1)) begin
			divCnt_nxt = '0;
			mClk_nxt = !mClk_r;
			if (mClk_r) begin
				// falling edge: data and word select change here
				mFall = 1'b1;
				if (bitCnt_r == CW'(W - 1)) begin
					bitCnt_nxt = '0;
					mBound = 1'b1;
					mWs_nxt = !mWs_r;
				end else begin
					bitCnt_nxt = bitCnt_r + 1'b1;
				end
			end
		end else begin
			divCnt_nxt = divCnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			divCnt_r <= '0;
			bitCnt_r <= CW'(W - 1);
			mClk_r <= `AS_IDLE_CLK;
			mWs_r <= `AS_IDLE_WS;
		end else begin
			divCnt_r <= divCnt_nxt;
			bitCnt_r <= bitCnt_nxt;
			mClk_r <= mClk_nxt;
			mWs_r <= mWs_nxt;
		end
	end

	// ---------------- slave tx pin synchronisers
	logic [2:0] sClkSync_r;
	logic [1:0] sWsSync_r;
	logic sWsSeen_r, sWsSeen_nxt;
	logic txListen, sFall, sBound;

	always_comb begin
		// pins are only looked at while listening as slave
		txListen = !txMaster && txActive;
		sFall = txListen && sClkSync_r[2] && !sClkSync_r[1];
		sBound = sFall && (sWsSync_r[1] != sWsSeen_r);
		sWsSeen_nxt = sFall ? sWsSync_r[1] : sWsSeen_r;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sClkSync_r <= '0;
			sWsSync_r <= '0;
			sWsSeen_r <= 1'b0;
		end else begin
			sClkSync_r <= {sClkSync_r[1:0], txBitClkIn};
			sWsSync_r <= {sWsSync_r[0], txWordSelIn};
			sWsSeen_r <= sWsSeen_nxt;
		end
	end

	// ---------------- transmit fifo and serialisers
	logic fifoValid, fifoReady, fifoPop;
	logic [TX_N*W-1:0] fifoData;

	stream_fifo #(.W(TX_N * W), .DEPTH(FIFO_DEPTH)) txFifo (
		.clk(clk),
		.arst_n(arst_n),
		.inValid(txValid),
		.inData(txData),
		.inReady(fifoReady),
		.outValid(fifoValid),
		.outData(fifoData),
		.outReady(fifoPop)
	);

	audio_serial_pkg::tx_state_e txState_r, txState_nxt;
	logic [W-1:0] shift_r [TX_N];
	logic [W-1:0] shift_nxt [TX_N];
	logic [TX_N-1:0] txSer_r, txSer_nxt;
	logic underrun_r, underrun_nxt;
	logic txShiftEv, txBound;

	always_comb begin
		txShiftEv = txMaster ? mFall : sFall;
		txBound = txMaster ? mBound : sBound;
		txState_nxt = txState_r;
		fifoPop = 1'b0;
		underrun_nxt = underrun_r && !softReset;
		shift_nxt = shift_r;
		case (txState_r)
			audio_serial_pkg::TX_IDLE: begin
				if (txActive && txBound)
					txState_nxt = audio_serial_pkg::TX_RUN;
			end
			audio_serial_pkg::TX_RUN: begin
				if (!txActive)
					txState_nxt = audio_serial_pkg::TX_IDLE;
			end
			default: txState_nxt = audio_serial_pkg::TX_IDLE;
		endcase
		if (txState_nxt == audio_serial_pkg::TX_RUN && txBound) begin
			// one fifo word per slot, missing data sends silence
			fifoPop = fifoValid;
			underrun_nxt = underrun_nxt || !fifoValid;
			for (int i = 0; i < TX_N; i++)
				shift_nxt[i] = fifoValid ? fifoData[i*W +: W] : '0;
		end else if (txShiftEv) begin
			for (int i = 0; i < TX_N; i++)
				shift_nxt[i] = {shift_r[i][W-2:0], 1'b0};
		end
		for (int i = 0; i < TX_N; i++) begin
			if (txState_nxt == audio_serial_pkg::TX_RUN && txOn[i])
				txSer_nxt[i] = shift_nxt[i][W-1];
			else
				txSer_nxt[i] = `AS_IDLE_DATA;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			txState_r <= audio_serial_pkg::TX_IDLE;
			for (int i = 0; i < TX_N; i++)
				shift_r[i] <= '0;
			txSer_r <= {TX_N{`AS_IDLE_DATA}};
			underrun_r <= 1'b0;
		end else begin
			txState_r <= txState_nxt;
			shift_r <= shift_nxt;
			txSer_r <= txSer_nxt;
			underrun_r <= underrun_nxt;
		end
	end

	// ---------------- pin drive registers
	logic rxClkOe_r, rxClkOe_nxt, rxWsOe_r, rxWsOe_nxt;
	logic txClkOe_r, txClkOe_nxt, txWsOe_r, txWsOe_nxt;
	logic rxClk_r, rxWs_r, txClk_r, txWs_r;

	always_comb begin
		// drive only as master and while running, float otherwise
		rxClkOe_nxt = rxMaster && rxActive;
		rxWsOe_nxt = rxMaster && rxActive;
		txClkOe_nxt = txMaster && txActive;
		txWsOe_nxt = txMaster && txActive;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rxClkOe_r <= 1'b0;
			rxWsOe_r <= 1'b0;
			txClkOe_r <= 1'b0;
			txWsOe_r <= 1'b0;
			rxClk_r <= `AS_IDLE_CLK;
			rxWs_r <= `AS_IDLE_WS;
			txClk_r <= `AS_IDLE_CLK;
			txWs_r <= `AS_IDLE_WS;
		end else begin
			rxClkOe_r <= rxClkOe_nxt;
			rxWsOe_r <= rxWsOe_nxt;
			txClkOe_r <= txClkOe_nxt;
			txWsOe_r <= txWsOe_nxt;
			rxClk_r <= mClk_nxt;
			rxWs_r <= mWs_nxt;
			txClk_r <= mClk_nxt;
			txWs_r <= mWs_nxt;
		end
	end

	// ---------------- receiver, on the receive bit clock
	logic rxRunLvl_r;
	logic [1:0] rxRunSync_r;
	audio_serial_pkg::rx_state_e rxState_r, rxState_nxt;
	logic [W-1:0] rxShift_r, rxShift_nxt, rxHold_r, rxHold_nxt;
	logic rxWsPrev_r, rxWsPrev_nxt, rxHoldRight_r, rxHoldRight_nxt;
	logic rxTog_r, rxTog_nxt, rxRunL;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			rxRunLvl_r <= 1'b0;
		else
			rxRunLvl_r <= rxActive;
	end

	always_comb begin
		rxRunL = rxRunSync_r[1];
		rxState_nxt = rxState_r;
		rxShift_nxt = rxShift_r;
		rxHold_nxt = rxHold_r;
		rxHoldRight_nxt = rxHoldRight_r;
		rxTog_nxt = rxTog_r;
		rxWsPrev_nxt = rxWsPrev_r;
		if (!rxRunL) begin
			// floating pins are not looked at
			rxState_nxt = audio_serial_pkg::RX_HUNT;
			rxShift_nxt = '0;
			rxWsPrev_nxt = `AS_IDLE_WS;
		end else begin
			rxWsPrev_nxt = rxWordSelIn;
			// sampled on the rising edge, first bit with the ws change
			if (rxWordSelIn != rxWsPrev_r) begin
				rxShift_nxt = {{(W-1){1'b0}}, rxSerialIn0};
				case (rxState_r)
					audio_serial_pkg::RX_HUNT: rxState_nxt = audio_serial_pkg::RX_LOCKED;
					audio_serial_pkg::RX_LOCKED: begin
						rxHold_nxt = rxShift_r;
						rxHoldRight_nxt = rxWsPrev_r;
						rxTog_nxt = !rxTog_r;
					end
					default: rxState_nxt = audio_serial_pkg::RX_HUNT;
				endcase
			end else begin
				rxShift_nxt = {rxShift_r[W-2:0], rxSerialIn0};
			end
		end
	end

	always_ff @(posedge rxLinkClk or negedge arst_n) begin
		if (!arst_n) begin
			rxRunSync_r <= '0;
			rxState_r <= audio_serial_pkg::RX_HUNT;
			rxShift_r <= '0;
			rxHold_r <= '0;
			rxHoldRight_r <= 1'b0;
			rxTog_r <= 1'b0;
			rxWsPrev_r <= `AS_IDLE_WS;
		end else begin
			rxRunSync_r <= {rxRunSync_r[0], rxRunLvl_r};
			rxState_r <= rxState_nxt;
			rxShift_r <= rxShift_nxt;
			rxHold_r <= rxHold_nxt;
			rxHoldRight_r <= rxHoldRight_nxt;
			rxTog_r <= rxTog_nxt;
			rxWsPrev_r <= rxWsPrev_nxt;
		end
	end

	// ---------------- word handover into clk domain
	logic [1:0] rxTogSync_r;
	logic rxTogSeen_r, rxNew;
	logic [W-1:0] rxWord_r, rxWord_nxt;
	logic rxRight_r, rxRight_nxt, rxValid_r, rxValid_nxt;

	always_comb begin
		// hold stays stable for a whole word after the toggle
		rxNew = rxTogSync_r[1] != rxTogSeen_r;
		rxValid_nxt = rxNew && rxActive;
		rxWord_nxt = rxNew ? rxHold_r : rxWord_r;
		rxRight_nxt = rxNew ? rxHoldRight_r : rxRight_r;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rxTogSync_r <= '0;
			rxTogSeen_r <= 1'b0;
			rxWord_r <= '0;
			rxRight_r <= 1'b0;
			rxValid_r <= 1'b0;
		end else begin
			rxTogSync_r <= {rxTogSync_r[0], rxTog_r};
			rxTogSeen_r <= rxTogSync_r[1];
			rxWord_r <= rxWord_nxt;
			rxRight_r <= rxRight_nxt;
			rxValid_r <= rxValid_nxt;
		end
	end

	// fifo ready flop itself, so ready never claims room already taken
	assign txReady = fifoReady;
	assign txUnderrun = underrun_r;
	assign rxWord = rxWord_r;
	assign rxWordRight = rxRight_r;
	assign rxWordValid = rxValid_r;
	assign rxBitClkOut = rxClk_r;
	assign rxBitClkOe = rxClkOe_r;
	assign rxWordSelOut = rxWs_r;
	assign rxWordSelOe = rxWsOe_r;
	assign txBitClkOut = txClk_r;
	assign txBitClkOe = txClkOe_r;
	assign txWordSelOut = txWs_r;
	assign txWordSelOe = txWsOe_r;
	assign txSerialOut = txSer_r;
endmodule : audio_serial_pin_control

//--- inc/audio_serial_regs.svh
`ifndef AUDIO_SERIAL_REGS_SVH
`define AUDIO_SERIAL_REGS_SVH
// bits per channel slot
`define AS_WORD_W 16
// clk cycles per half period of the generated bit clock
`define AS_BCLK_HALF 4
`define AS_FIFO_DEPTH 16
`define AS_TX_COUNT 3
// level of a serial output while its transmitter is idle
`define AS_IDLE_DATA 1'b1
// generated clock and word select level while stopped
`define AS_IDLE_CLK 1'b0
`define AS_IDLE_WS 1'b0
`endif

//--- inc/audio_serial_pkg.sv
package audio_serial_pkg;
	typedef enum logic {TX_IDLE, TX_RUN} tx_state_e;
	typedef enum logic {RX_HUNT, RX_LOCKED} rx_state_e;
endpackage : audio_serial_pkg

//--- rtl/stream_fifo.sv
`timescale 1ns/1ps
module stream_fifo #(
	parameter int W = 48,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic inValid,
	input wire logic [W-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [W-1:0] outData,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1)
			$error("stream_fifo: DEPTH must be a power of two >= 2");
	end

	logic [W-1:0] mem_r [DEPTH];
	logic [W-1:0] mem_nxt [DEPTH];
	logic [AW:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
	logic inReady_r, inReady_nxt, outValid_r, outValid_nxt;
	logic push, pop;
	logic [AW:0] fill;

	always_comb begin
		push = inValid && inReady_r;
		pop = outReady && outValid_r;
		mem_nxt = mem_r;
		if (push)
			mem_nxt[wrPtr_r[AW-1:0]] = inData;
		wrPtr_nxt = push ? wrPtr_r + 1'b1 : wrPtr_r;
		rdPtr_nxt = pop ? rdPtr_r + 1'b1 : rdPtr_r;
		fill = wrPtr_nxt - rdPtr_nxt;
		// flags registered so the ready seen outside comes from a flop
		inReady_nxt = fill != DEPTH[AW:0];
		outValid_nxt = fill != '0;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DEPTH; i++)
				mem_r[i] <= '0;
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			inReady_r <= 1'b0;
			outValid_r <= 1'b0;
		end else begin
			mem_r <= mem_nxt;
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			inReady_r <= inReady_nxt;
			outValid_r <= outValid_nxt;
		end
	end

	assign inReady = inReady_r;
	assign outValid = outValid_r;
	assign outData = mem_r[rdPtr_r[AW-1:0]];
endmodule : stream_fifo

//--- tb/audio_serial_monitor.sv
`timescale 1ns/1ps
module audio_serial_monitor #(
	parameter int TX_N = 3,
	parameter int BCLK_HALF = 4
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic rxMaster,
	input wire logic txMaster,
	input wire logic rxEnable0,
	input wire logic [TX_N-1:0] txEnable,
	input wire logic softReset,
	input wire logic stopMode,
	input wire logic txUnderrun,
	input wire logic rxWordValid,
	input wire logic rxBitClkOe,
	input wire logic rxWordSelOe,
	input wire logic txBitClkOut,
	input wire logic txBitClkOe,
	input wire logic txWordSelOe,
	input wire logic [TX_N-1:0] txSerialOut
);
	logic rxOn;
	logic txOn;
	logic [7:0] hiLen_r;
	assign rxOn = rxEnable0 && !softReset && !stopMode;
	assign txOn = (|txEnable) && !softReset && !stopMode;
	// high phase length of the generated bit clock
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hiLen_r <= 8'h00;
		end else begin
			hiLen_r <= txBitClkOut ? hiLen_r + 8'h01 : 8'h00;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_rxws_drive: assert property (1 |=> rxWordSelOe == $past(rxOn && rxMaster))
		else $error("rx ws drive");
	a_rxclk_pair: assert property (rxBitClkOe == rxWordSelOe)
		else $error("rx clock drive");
	a_txclk_drive: assert property (1 |=> txBitClkOe == $past(txOn && txMaster))
		else $error("tx clock drive");
	a_txws_pair: assert property (txWordSelOe == txBitClkOe)
		else $error("tx ws drive");
	a_idle_high: assert property (1 |=> (~txSerialOut & ~$past(txEnable)) == '0)
		else $error("idle output low");
	a_edge_align: assert property (txBitClkOe && $past(txBitClkOe)
		&& $past(txEnable) == $past(txEnable, 2) && $changed(txSerialOut) |-> $fell(txBitClkOut))
		else $error("data off falling edge");
	a_bclk_half: assert property (txBitClkOe && $fell(txBitClkOut) |-> hiLen_r == BCLK_HALF)
		else $error("bit clock half period");
	a_rx_quiet: assert property ((!rxOn) [*6] |-> !rxWordValid)
		else $error("rx word while off");
	cover property ($rose(txBitClkOe));
	cover property (rxWordValid);
	cover property ($rose(txUnderrun));
endmodule : audio_serial_monitor
bind audio_serial_pin_control audio_serial_monitor #(.TX_N(TX_N), .BCLK_HALF(BCLK_HALF)) mon_u (.*);

//--- tb/audio_codec_model.sv
`timescale 1ns/1ps
module audio_codec_model (
	input wire logic clk,
	input wire logic txBitClkOut,
	input wire logic txBitClkOe,
	input wire logic txWordSelOut,
	input wire logic [2:0] txSerialOut,
	output logic linkClk,
	output logic linkWs,
	output logic linkData
);
	logic [47:0] shiftR = 48'h0;
	logic [4:0] bitCnt = 5'h0;
	logic wsSeen = 1'b0;
	logic linkRun = 1'b0;
	logic [47:0] got[$];
	initial begin
		linkClk = 1'b0;
		linkWs = 1'b0;
		linkData = 1'b0;
	end
	// capture device slots on rising edge, slot opens on ws change
	always @(posedge txBitClkOut) begin
		if (txBitClkOe) begin
			if (txWordSelOut != wsSeen) begin
				if (bitCnt == 5'h10) got.push_back(shiftR);
				bitCnt = 5'h0;
				wsSeen = txWordSelOut;
			end
			shiftR = {shiftR[46:32], txSerialOut[2], shiftR[30:16], txSerialOut[1],
				shiftR[14:0], txSerialOut[0]};
			if (bitCnt < 5'h1F) bitCnt = bitCnt + 5'h01;
		end
	end
	// new drive period starts with a fresh slot count
	always @(posedge txBitClkOe) begin
		wsSeen = 1'b0;
		bitCnt = 5'h0;
	end
	// released data line keeps changing
	always @(posedge clk) begin
		if (!linkRun) linkData <= ~linkData;
	end
	task automatic sendWords(input logic [71:0] w);
		linkRun = 1'b1;
		#3.3;
		for (int i = 0; i < 72; i++) begin
			#7.5 linkClk = 1'b0;
			linkData = w[71-i];
			if (i % 16 == 0) linkWs = ~linkWs;
			#7.5 linkClk = 1'b1;
		end
		#7.5 linkClk = 1'b0;
		linkRun = 1'b0;
	endtask : sendWords
endmodule : audio_codec_model

//--- tb/tb_audio_serial_pin_control.sv
`timescale 1ns/1ps
module tb_audio_serial_pin_control;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic rxMaster = 1'b0;
	logic txMaster = 1'b0;
	logic rxEnable0 = 1'b0;
	logic [2:0] txEnable = 3'h0;
	logic softReset = 1'b0;
	logic stopMode = 1'b0;
	logic txValid = 1'b0;
	logic [47:0] txData = 48'h0;
	logic txReady, txUnderrun, rxWordRight, rxWordValid, rxBitClkOut, rxBitClkOe;
	logic rxWordSelOut, rxWordSelOe, txBitClkOut, txBitClkOe, txWordSelOut, txWordSelOe;
	logic [15:0] rxWord;
	logic [2:0] txSerialOut;
	logic codecClk, codecWs, codecSd, rxClkPin, rxWsPin, txClkPin, txWsPin;
	integer seed = 32'hDA33;
	int n_fail = 0;
	int checked = 0;
	int cycles = 0;
	logic [47:0] sent[$];
	logic [16:0] rxGot[$];
	always #12.5 clk = ~clk;
	assign rxClkPin = rxBitClkOe ? rxBitClkOut : codecClk;
	assign rxWsPin = rxWordSelOe ? rxWordSelOut : codecWs;
	assign txClkPin = txBitClkOe ? txBitClkOut : 1'b0;
	assign txWsPin = txWordSelOe ? txWordSelOut : 1'b0;
	audio_serial_pin_control dut_u (.clk(clk), .arst_n(arst_n), .rxLinkClk(rxClkPin),
		.rxMaster(rxMaster), .txMaster(txMaster), .rxEnable0(rxEnable0), .txEnable(txEnable),
		.softReset(softReset), .stopMode(stopMode), .txValid(txValid), .txData(txData),
		.txReady(txReady), .txUnderrun(txUnderrun), .rxWord(rxWord), .rxWordRight(rxWordRight),
		.rxWordValid(rxWordValid), .rxBitClkOut(rxBitClkOut), .rxBitClkOe(rxBitClkOe),
		.rxWordSelIn(rxWsPin), .rxWordSelOut(rxWordSelOut), .rxWordSelOe(rxWordSelOe),
		.rxSerialIn0(codecSd), .txBitClkIn(txClkPin), .txBitClkOut(txBitClkOut),
		.txBitClkOe(txBitClkOe), .txWordSelIn(txWsPin), .txWordSelOut(txWordSelOut),
		.txWordSelOe(txWordSelOe), .txSerialOut(txSerialOut));
	audio_codec_model codec_u (.clk(clk), .txBitClkOut(txBitClkOut), .txBitClkOe(txBitClkOe),
		.txWordSelOut(txWordSelOut), .txSerialOut(txSerialOut), .linkClk(codecClk),
		.linkWs(codecWs), .linkData(codecSd));
	function automatic logic [3:0] oeExp(input logic rm, input logic tm, input logic e0,
		input logic [2:0] te, input logic sr, input logic st);
		logic rOn;
		logic tOn;
		rOn = e0 && !sr && !st;
		tOn = (|te) && !sr && !st;
		return {rOn && rm, rOn && rm, tOn && tm, tOn && tm};
	endfunction : oeExp
	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (rxWordValid === 1'b1) rxGot.push_back({rxWordRight, rxWord});
		if (cycles == 10000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		logic [7:0] r;
		logic [71:0] w;
		repeat (10) @(posedge clk);
		chk("oeReset", 48'h0, {rxBitClkOe, rxWordSelOe, txBitClkOe, txWordSelOe});
		chk("sdoReset", 48'h7, txSerialOut);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		$display("test reset done");
		for (int i = 0; i < 40; i++) begin
			r = 8'($random(seed));
			{rxMaster, txMaster, rxEnable0, txEnable} <= r[5:0];
			softReset <= (i % 5 == 1);
			stopMode <= (i % 7 == 3);
			repeat (6) @(posedge clk);
			chk("oe", oeExp(rxMaster, txMaster, rxEnable0, txEnable, softReset, stopMode),
				{rxBitClkOe, rxWordSelOe, txBitClkOe, txWordSelOe});
			chk("sdoIdle", 48'h7, txSerialOut | (txEnable & {3{!softReset && !stopMode}}));
		end
		softReset <= 1'b1;
		repeat (2) @(posedge clk);
		{rxMaster, txMaster, rxEnable0, txEnable, softReset, stopMode} <= 8'h00;
		repeat (2) @(posedge clk);
		codec_u.got.delete();
		$display("test gating done");
		txValid <= 1'b1;
		txData <= 48'({$random(seed), $random(seed)});
		for (int i = 0; i < 24; i++) begin
			@(posedge clk);
			if (txReady === 1'b1) begin
				sent.push_back(txData);
				txData <= 48'({$random(seed), $random(seed)});
			end
		end
		txValid <= 1'b0;
		chk("fillCount", 48'h10, 48'(sent.size()));
		txMaster <= 1'b1;
		txEnable <= 3'h7;
		for (int k = 0; k < 4000 && txUnderrun !== 1'b1; k++) @(posedge clk);
		repeat (20) @(posedge clk);
		chk("underrun", 48'h1, txUnderrun);
		while (codec_u.got.size() > 0 && codec_u.got[0] === 48'hFFFF_FFFF_FFFF)
			void'(codec_u.got.pop_front());
		foreach (sent[i]) chk("txWord", sent[i], codec_u.got[i]);
		txMaster <= 1'b0;
		txEnable <= 3'h0;
		rxEnable0 <= 1'b1;
		$display("test transmit done");
		repeat (4) @(posedge clk);
		w = 72'({$random(seed), $random(seed), $random(seed)});
		codec_u.sendWords(w);
		repeat (12) @(posedge clk);
		chk("rxLast", {1'b0, w[23:8]}, rxGot[$]);
		chk("rxPrev", {1'b1, w[39:24]}, rxGot[$-1]);
		$display("test receive done");
		summarize();
	end
endmodule : tb_audio_serial_pin_control
